// *** verilog/tsc_pkg.sv ***
/*
 * tsc_pkg: register map, field positions, reset values and carrier types
 * of the touch status and control register bank.
 * assumes: one clock, register offsets are those seen by the two-wire link decoder.
 */
package tsc_pkg;

   localparam int NUM_INPUTS = 3;

   // register offsets
   localparam logic [7:0] ADDR_POWER_STATE_CONTROL = 8'h00;
   localparam logic [7:0] ADDR_GENERAL_STATUS      = 8'h02;
   localparam logic [7:0] ADDR_INPUT_TOUCH_STATUS  = 8'h03;
   localparam logic [7:0] ADDR_INPUT_NOISE_FLAGS   = 8'h0a;
   localparam logic [7:0] ADDR_INPUT1_DELTA        = 8'h10;
   localparam logic [7:0] ADDR_INPUT2_DELTA        = 8'h11;
   localparam logic [7:0] ADDR_INPUT3_DELTA        = 8'h12;
   localparam logic [7:0] ADDR_SENSITIVITY_CONTROL = 8'h1f;

   // power state control fields
   localparam int BIT_STANDBY_ENABLE    = 5;
   localparam int BIT_DEEP_SLEEP_ENABLE = 4;
   localparam int BIT_INT_PENDING       = 0;

   // general status fields
   localparam int BIT_BASE_COUNT_LIMIT = 6;
   localparam int BIT_ANALOG_CAL_FAIL  = 5;
   localparam int BIT_POWER_KEY_HELD   = 4;
   localparam int BIT_MULTI_BLOCKING   = 2;
   localparam int BIT_PATTERN_MATCH    = 1;
   localparam int BIT_ANY_TOUCH        = 0;

   // sensitivity control fields
   localparam int SENS_SCALE_LSB = 4;
   localparam int BASE_SCALE_LSB = 0;

   // reset values
   localparam logic [7:0] RST_POWER_STATE_CONTROL = 8'h00;
   localparam logic [7:0] RST_STATUS              = 8'h00;
   localparam logic [7:0] RST_DELTA               = 8'h00;
   localparam logic [7:0] RST_SENSITIVITY_CONTROL = 8'h20;

   // delta saturation limits
   localparam logic [7:0] DELTA_POS_MAX = 8'h7f;
   localparam logic [7:0] DELTA_NEG_MIN = 8'h80;

   // static configuration held by neighbouring register blocks
   typedef struct packed {
      logic [NUM_INPUTS-1:0]      activeEnable;
      logic [NUM_INPUTS-1:0]      standbyChannel;
      logic [NUM_INPUTS-1:0]      intEnable;
      logic                       patternIrqEnable;
      logic                       lowfreqNoiseIgnore;
      logic                       radioNoiseIgnore;
      logic [NUM_INPUTS-1:0][7:0] touchThreshold;
      logic [7:0]                 patternThreshold;
   } tsc_cfg_t;

   // reports from the analog front end and the sensing engines
   typedef struct packed {
      logic                        sampleStrobe;
      logic [NUM_INPUTS-1:0][15:0] rawDelta;
      logic [NUM_INPUTS-1:0]       noiseReport;
      logic [NUM_INPUTS-1:0]       lowfreqNoise;
      logic [NUM_INPUTS-1:0]       radioNoise;
      logic [NUM_INPUTS-1:0]       baseOutLimit;
      logic [NUM_INPUTS-1:0]       calFailed;
      logic                        powerKeyHeld;
      logic                        powerKeyTouched;
      logic                        multiTouchBlock;
      logic                        patternExceeded;
   } tsc_sense_t;

   typedef struct packed {
      logic                       standbyEnable;
      logic                       deepSleepEnable;
      logic                       intPending;
      logic [7:0]                 sensCtl;
      logic [NUM_INPUTS-1:0]      touchStat;
      logic [NUM_INPUTS-1:0]      touchNow;
      logic [NUM_INPUTS-1:0]      noiseFlags;
      logic                       baseCountLimitFlag;
      logic                       analogCalFailed;
      logic                       powerKeyHeld;
      logic                       powerKeyPrev;
      logic                       multiTouchBlocking;
      logic                       patternMatchFlag;
      logic                       patternPrev;
      logic [NUM_INPUTS-1:0][7:0] delta;
      logic [7:0]                 rdData;
   } tsc_state_t;

endpackage : tsc_pkg

// *** verilog/tsc_regs.sv ***
/*
 * tsc_regs: control and status register bank of a three-input touch controller:
 * power states, interrupt pending with attention output, touch and noise status,
 * saturating delta counts and sensitivity scaling.
 * assumes: the two-wire link decoder presents single-cycle register reads and writes;
 * analog front end and engines report synchronously to mclk.
 */
// How it works
// - standby scans only the inputs chosen by the standby channel selection
// - standby keeps status until read; unsampled inputs release once then stay untouched
// - deep sleep stops scanning, clears all status and the interrupt pending bit
// - deep sleep overrides standby
// - interrupt pending drives the active-low attention output
// - touch on an input with interrupt disabled never raises interrupt pending
// - host writes zero to clear pending; status clears where its cause is gone
// - base count limit flag set while any enabled input is out of limit
// - calibration failed flag set while any enabled input failed calibration
// - power key held flag raises pending; clears on pending clear once released
// - multi-touch blocking flag shows suppression and never raises pending
// - pattern flag raises pending only if enabled; clears on pending clear when gone
// - any-touch flag is the OR of the per-input touch status bits
// - held touch survives a pending clear and does not raise pending again
// - noise flags follow the live report; noisy input has zero delta, no touch
// - noisy input counts once as over the pattern threshold
// - low-frequency or radio noise samples are dropped unless their ignore bit is set
// - delta is signed, updated once per input per sensing cycle, compared to threshold
// - delta saturates at 7fh and 80h
// - sensitivity code 000b is 128x down to 111b at 1x, default 32x
// - base count scale only changes base count presentation
// - reset loads every register with its default
`timescale 1ns/1ps
module tsc_regs
   import tsc_pkg::*;
#(
   parameter int N = NUM_INPUTS
) (
   // clock and reset
   input  wire logic             mclk,
   input  wire logic             srst,
   // register port from the link decoder
   input  wire logic [7:0]       regAddr,
   input  wire logic             regWrEn,
   input  wire logic [7:0]       regWrData,
   input  wire logic             regRdEn,
   output logic      [7:0]       regRdData,
   // configuration and front-end reports
   input  wire tsc_cfg_t         cfg,
   input  wire tsc_sense_t       sense,
   // outputs to pin and engines
   output logic                  alertN,
   output logic      [N-1:0]     scanEnable,
   output logic      [2:0]       deltaScale,
   output logic      [3:0]       baseShift,
   output logic      [N-1:0]     patternOver,
   output logic      [1:0]       patternCount
);

   tsc_state_t st_reg;
   tsc_state_t st_next;

   // scale a raw count by 2**(7-code) and saturate to a signed byte
   function automatic logic [7:0] scale_sat(input logic [15:0] raw, input logic [2:0] code);
      logic signed [23:0] wide;
      wide = $signed({{8{raw[15]}}, raw}) <<< (~code);
      if (wide > 24'sd127) begin
         scale_sat = DELTA_POS_MAX;
      end else if (wide < -24'sd128) begin
         scale_sat = DELTA_NEG_MIN;
      end else begin
         scale_sat = wide[7:0];
      end
   endfunction : scale_sat

   logic [N-1:0] scanNow;
   logic [N-1:0] discard;
   logic [N-1:0] enabledIn;
   logic [N-1:0] newTouch;
   logic         wrCtl;
   logic         intClear;
   logic         rdTouch;

   always_comb begin
      enabledIn = st_reg.standbyEnable ? cfg.standbyChannel : cfg.activeEnable;
      scanNow   = st_reg.deepSleepEnable ? '0 : enabledIn;
      discard   = (sense.lowfreqNoise & {N{~cfg.lowfreqNoiseIgnore}})
                | (sense.radioNoise & {N{~cfg.radioNoiseIgnore}});
      wrCtl     = regWrEn && regAddr == ADDR_POWER_STATE_CONTROL;
      intClear  = wrCtl && !regWrData[BIT_INT_PENDING] && st_reg.intPending;
      rdTouch   = regRdEn && regAddr == ADDR_INPUT_TOUCH_STATUS;
   end

   always_comb begin
      logic [N-1:0] clrTouch;
      logic         setInt;
      logic [7:0]   rd;
      clrTouch = '0;
      setInt   = 1'b0;
      rd       = 8'h00;
      st_next  = st_reg;
      newTouch = '0;

      // power state control; reserved bits dropped
      if (wrCtl) begin
         st_next.standbyEnable   = regWrData[BIT_STANDBY_ENABLE];
         st_next.deepSleepEnable = regWrData[BIT_DEEP_SLEEP_ENABLE];
      end
      if (regWrEn && regAddr == ADDR_SENSITIVITY_CONTROL) begin
         st_next.sensCtl = {1'b0, regWrData[6:0]};
      end

      // per-input sampling once per sensing cycle
      st_next.noiseFlags = sense.noiseReport & scanNow;
      for (int i = 0; i < N; i++) begin
         if (!scanNow[i]) begin
            st_next.touchNow[i] = 1'b0;
            st_next.delta[i]    = RST_DELTA;
         end else if (sense.noiseReport[i]) begin
            // held at zero for as long as the input reports noise
            st_next.delta[i]    = RST_DELTA;
            st_next.touchNow[i] = 1'b0;
         end else if (sense.sampleStrobe && !discard[i]) begin
            st_next.delta[i]    = scale_sat(sense.rawDelta[i], st_reg.sensCtl[6:4]);
            st_next.touchNow[i] = $signed(st_next.delta[i])
                                >= $signed({1'b0, cfg.touchThreshold[i][6:0]});
         end
         newTouch[i] = st_next.touchNow[i] && !st_reg.touchNow[i];
      end

      // interrupt pending clear takes away status whose cause is gone
      if (intClear) begin
         st_next.intPending = 1'b0;
         clrTouch           = ~st_next.touchNow;
         if (!sense.powerKeyTouched) begin
            st_next.powerKeyHeld = 1'b0;
         end
         if (!sense.patternExceeded) begin
            st_next.patternMatchFlag = 1'b0;
         end
      end
      if (rdTouch && st_reg.standbyEnable) begin
         clrTouch = clrTouch | ~st_next.touchNow;
      end
      st_next.touchStat = (st_reg.touchStat & ~clrTouch) | newTouch;         // set wins

      // new events raise interrupt pending
      if (|(newTouch & cfg.intEnable)) begin
         setInt = 1'b1;
      end
      st_next.powerKeyPrev = sense.powerKeyHeld;
      if (sense.powerKeyHeld && !st_reg.powerKeyPrev) begin
         st_next.powerKeyHeld = 1'b1;
         setInt               = 1'b1;
      end
      st_next.patternPrev = sense.patternExceeded;
      if (sense.patternExceeded && !st_reg.patternPrev) begin
         st_next.patternMatchFlag = 1'b1;
         setInt                   = setInt | cfg.patternIrqEnable;
      end
      if (setInt) begin
         st_next.intPending = 1'b1;
      end

      // level flags; multi-touch blocking has no path into setInt
      st_next.baseCountLimitFlag = |(sense.baseOutLimit & enabledIn);
      st_next.analogCalFailed    = |(sense.calFailed & enabledIn);
      st_next.multiTouchBlocking = sense.multiTouchBlock;

      // deep sleep wipes all status
      if (st_reg.deepSleepEnable) begin
         st_next.intPending         = 1'b0;
         st_next.touchStat          = '0;
         st_next.touchNow           = '0;
         st_next.noiseFlags         = '0;
         st_next.baseCountLimitFlag = 1'b0;
         st_next.analogCalFailed    = 1'b0;
         st_next.powerKeyHeld       = 1'b0;
         st_next.multiTouchBlocking = 1'b0;
         st_next.patternMatchFlag   = 1'b0;
      end

      // read mux; unmapped and reserved bits read zero
      case (regAddr)
         ADDR_POWER_STATE_CONTROL: begin
            rd[BIT_STANDBY_ENABLE]    = st_reg.standbyEnable;
            rd[BIT_DEEP_SLEEP_ENABLE] = st_reg.deepSleepEnable;
            rd[BIT_INT_PENDING]       = st_reg.intPending;
         end
         ADDR_GENERAL_STATUS: begin
            rd[BIT_BASE_COUNT_LIMIT] = st_reg.baseCountLimitFlag;
            rd[BIT_ANALOG_CAL_FAIL]  = st_reg.analogCalFailed;
            rd[BIT_POWER_KEY_HELD]   = st_reg.powerKeyHeld;
            rd[BIT_MULTI_BLOCKING]   = st_reg.multiTouchBlocking;
            rd[BIT_PATTERN_MATCH]    = st_reg.patternMatchFlag;
            rd[BIT_ANY_TOUCH]        = |st_reg.touchStat;
         end
         ADDR_INPUT_TOUCH_STATUS: rd[N-1:0] = st_reg.touchStat;
         ADDR_INPUT_NOISE_FLAGS:  rd[N-1:0] = st_reg.noiseFlags;
         ADDR_INPUT1_DELTA:       rd = st_reg.delta[0];
         ADDR_INPUT2_DELTA:       rd = st_reg.delta[1];
         ADDR_INPUT3_DELTA:       rd = st_reg.delta[2];
         ADDR_SENSITIVITY_CONTROL: rd = st_reg.sensCtl;
         default:                 rd = 8'h00;
      endcase
      if (regRdEn) begin
         st_next.rdData = rd;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         st_reg                    <= '0;
         st_reg.standbyEnable      <= RST_POWER_STATE_CONTROL[BIT_STANDBY_ENABLE];
         st_reg.deepSleepEnable    <= RST_POWER_STATE_CONTROL[BIT_DEEP_SLEEP_ENABLE];
         st_reg.intPending         <= RST_POWER_STATE_CONTROL[BIT_INT_PENDING];
         st_reg.sensCtl            <= RST_SENSITIVITY_CONTROL;
         st_reg.delta              <= {N{RST_DELTA}};
         st_reg.rdData             <= RST_STATUS;
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs
   always_comb begin
      alertN     = ~st_reg.intPending;
      regRdData  = st_reg.rdData;
      scanEnable = scanNow;
      deltaScale = st_reg.sensCtl[6:4];
      baseShift  = st_reg.sensCtl[3:0];
      patternCount = '0;
      for (int i = 0; i < N; i++) begin
         patternOver[i] = st_reg.noiseFlags[i]
                        || $signed(st_reg.delta[i]) >= $signed({1'b0, cfg.patternThreshold[6:0]});
         patternCount   = patternCount + 2'(patternOver[i]);
      end
   end

   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);

   sequence s_sleepWrite;
      wrCtl && regWrData[BIT_DEEP_SLEEP_ENABLE];
   endsequence

   sequence s_sleeping;
      st_reg.deepSleepEnable [*2];
   endsequence

   chk_alert_follows_int: assert property (alertN == !st_reg.intPending)
      else $error("attention output disagrees with interrupt pending");

   chk_sleep_clears_int: assert property (s_sleepWrite ##1 s_sleeping
                                          |-> !st_reg.intPending && st_reg.touchStat == '0)
      else $error("deep sleep left status or pending set");

   chk_sleep_over_standby: assert property (st_reg.deepSleepEnable
                                            |-> scanEnable == '0)
      else $error("input scanned during deep sleep");

   chk_standby_scan_mask: assert property (st_reg.standbyEnable && !st_reg.deepSleepEnable
                                           |-> scanEnable == cfg.standbyChannel)
      else $error("standby scanning wrong inputs");

   chk_any_touch_or: assert property (regRdEn && regAddr == ADDR_GENERAL_STATUS
                                      |=> regRdData[BIT_ANY_TOUCH] == |$past(st_reg.touchStat))
      else $error("any-touch flag not the OR of touch status");

   chk_noise_zero_delta: assert property (scanNow[2] && sense.noiseReport[2]
                                          |=> st_reg.delta[2] == 8'h00 && !st_reg.touchNow[2])
      else $error("noisy input kept a delta or touch");

   chk_int_needs_cause: assert property (!st_reg.intPending ##1 st_reg.intPending
                                         |-> $past(|(newTouch & cfg.intEnable)
                                                   || (sense.powerKeyHeld && !st_reg.powerKeyPrev)
                                                   || (sense.patternExceeded && !st_reg.patternPrev
                                                       && cfg.patternIrqEnable)))
      else $error("interrupt pending rose without an enabled cause");

   chk_held_touch_kept: assert property (intClear && st_reg.touchStat[0] && st_next.touchNow[0]
                                         && !st_reg.deepSleepEnable
                                         |=> st_reg.touchStat[0] && !st_reg.intPending)
      else $error("held touch lost or pending reasserted on clear");

   chk_touch_sets_int: assert property (newTouch[0] && cfg.intEnable[0] && !st_reg.deepSleepEnable
                                        |=> st_reg.intPending ##1 !alertN)
      else $error("enabled new touch did not raise pending");

endmodule : tsc_regs

// *** tb/tsc_host_model.sv ***
/*
 * tsc_host_model: link-side master issuing single-byte register reads and writes.
 * assumes: the register port takes a strobe at a rising edge and answers a read
 * the cycle after.
 */
`timescale 1ns/1ps
module tsc_host_model (
   // clock
   input  wire logic       mclk,
   // register port
   output logic      [7:0] regAddr,
   output logic            regWrEn,
   output logic      [7:0] regWrData,
   output logic            regRdEn,
   input  wire logic [7:0] regRdData
);
   initial begin
      regAddr   = 8'h00;
      regWrEn   = 1'b0;
      regWrData = 8'h00;
      regRdEn   = 1'b0;
   end

   // zero in bit 0 of the power state byte clears the pending flag
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      regAddr   <= a;
      regWrData <= d;
      regWrEn   <= 1'b1;
      @(posedge mclk);
      regWrEn   <= 1'b0;
      regAddr   <= ~a;
      regWrData <= ~d;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge mclk);
      regRdEn <= 1'b0;
      regAddr <= ~a;
      #1;
      d = regRdData;
   endtask : rd
endmodule : tsc_host_model

// *** tb/tb.sv ***
/*
 * tb: self-checking bench of the touch status and control register bank.
 * assumes: tsc_host_model drives the register port; the bench plays the front end.
 */
`timescale 1ns/1ps
module tb;
   import tsc_pkg::*;

   localparam logic [7:0] ADDRS [9] = '{8'h00, 8'h02, 8'h03, 8'h0a, 8'h10, 8'h11, 8'h12,
                                        8'h1f, 8'h05};
   localparam logic [7:0] RSTV  [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                        8'h20, 8'h00};

   logic       mclk;
   logic       srst;
   logic [7:0] regAddr;
   logic       regWrEn;
   logic [7:0] regWrData;
   logic       regRdEn;
   logic [7:0] regRdData;
   tsc_cfg_t   cfg;
   tsc_sense_t sense;
   logic       alertN;
   logic [2:0] scanEnable;
   logic [2:0] deltaScale;
   logic [3:0] baseShift;
   logic [2:0] patternOver;
   logic [1:0] patternCount;
   int         n_errors;
   int         comparisons;
   int         cycles;

   tsc_regs DUT (.mclk(mclk), .srst(srst), .regAddr(regAddr), .regWrEn(regWrEn),
      .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData), .cfg(cfg),
      .sense(sense), .alertN(alertN), .scanEnable(scanEnable), .deltaScale(deltaScale),
      .baseShift(baseShift), .patternOver(patternOver), .patternCount(patternCount));

   tsc_host_model host (.mclk(mclk), .regAddr(regAddr), .regWrEn(regWrEn),
      .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : final_report

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      host.rd(a, d);
      check($sformatf("reg %h", a), d, exp);
   endtask : rdChk

   task automatic strobe();
      @(posedge mclk);
      sense.sampleStrobe <= 1'b1;
      @(posedge mclk);
      sense.sampleStrobe <= 1'b0;
      @(posedge mclk);
   endtask : strobe

   // hang guard: the sequence needs well under 2000 cycles
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_errors++;
         final_report();
      end
   end

   initial begin
      cycles = 0;
      n_errors = 0;
      comparisons = 0;
      cfg = '0;
      sense = '0;
      srst = 1'b1;
      repeat (5) @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      #1;
      check("alertN", {7'h00, alertN}, 8'h01);
      for (int i = 0; i < 9; i++) rdChk(ADDRS[i], RSTV[i]);
      $display("test defaults done");

      @(posedge mclk);
      cfg.activeEnable <= 3'b111;
      cfg.intEnable <= 3'b001;
      cfg.touchThreshold <= {3{8'h40}};
      cfg.patternThreshold <= 8'h10;
      sense.rawDelta <= {16'h0010, 16'hfff0, 16'h0010};
      strobe();
      rdChk(8'h10, 8'h7f);
      rdChk(8'h11, 8'h80);
      rdChk(8'h03, 8'h05);
      rdChk(8'h02, 8'h01);
      rdChk(8'h00, 8'h01);
      check("alertN", {7'h00, alertN}, 8'h00);
      host.wr(8'h00, 8'h00);
      #1;
      check("alertN", {7'h00, alertN}, 8'h01);
      rdChk(8'h00, 8'h00);
      rdChk(8'h03, 8'h05);
      @(posedge mclk);
      sense.rawDelta[2] <= 16'h0000;
      strobe();
      @(posedge mclk);
      sense.rawDelta[2] <= 16'h0010;
      strobe();
      rdChk(8'h00, 8'h00);
      $display("test touch and pending done");

      @(posedge mclk);
      sense.noiseReport <= 3'b100;
      strobe();
      rdChk(8'h0a, 8'h04);
      rdChk(8'h12, 8'h00);
      check("patternOver", {5'h00, patternOver}, 8'h05);
      check("patternCount", {6'h00, patternCount}, 8'h02);
      @(posedge mclk);
      sense.noiseReport <= 3'b000;
      repeat (2) @(posedge mclk);
      rdChk(8'h0a, 8'h00);
      @(posedge mclk);
      sense.lowfreqNoise <= 3'b001;
      sense.radioNoise <= 3'b010;
      sense.rawDelta <= '0;
      strobe();
      rdChk(8'h10, 8'h7f);
      rdChk(8'h11, 8'h80);
      @(posedge mclk);
      cfg.lowfreqNoiseIgnore <= 1'b1;
      cfg.radioNoiseIgnore <= 1'b1;
      strobe();
      rdChk(8'h10, 8'h00);
      rdChk(8'h11, 8'h00);
      $display("test noise done");

      @(posedge mclk);
      sense.baseOutLimit <= 3'b001;
      sense.calFailed <= 3'b010;
      sense.multiTouchBlock <= 1'b1;
      sense.patternExceeded <= 1'b1;
      repeat (2) @(posedge mclk);
      rdChk(8'h02, 8'h67);
      rdChk(8'h00, 8'h00);
      @(posedge mclk);
      sense.powerKeyHeld <= 1'b1;
      sense.powerKeyTouched <= 1'b1;
      repeat (2) @(posedge mclk);
      rdChk(8'h02, 8'h77);
      rdChk(8'h00, 8'h01);
      @(posedge mclk);
      sense.baseOutLimit <= 3'b000;
      sense.calFailed <= 3'b000;
      sense.multiTouchBlock <= 1'b0;
      sense.patternExceeded <= 1'b0;
      sense.powerKeyHeld <= 1'b0;
      sense.powerKeyTouched <= 1'b0;
      host.wr(8'h00, 8'h00);
      rdChk(8'h02, 8'h00);
      rdChk(8'h03, 8'h00);
      $display("test general status done");

      @(posedge mclk);
      sense.rawDelta[0] <= 16'h0001;
      for (int c = 0; c < 8; c++) begin
         host.wr(8'h1f, {1'b1, 3'(c), 4'(c)});
         strobe();
         rdChk(8'h1f, {1'b0, 3'(c), 4'(c)});
         check("deltaScale", {5'h00, deltaScale}, 8'(c));
         check("baseShift", {4'h0, baseShift}, 8'(c));
         rdChk(8'h10, (c == 0) ? 8'h7f : 8'(1 << (7 - c)));
      end
      $display("test sensitivity done");

      host.wr(8'h00, 8'h00);
      @(posedge mclk);
      cfg.standbyChannel <= 3'b010;
      cfg.intEnable <= 3'b011;
      // sensitivity is left at 1x by the loop above, so the raw count must clear the threshold
      sense.rawDelta[1] <= 16'h0050;
      host.wr(8'h00, 8'h20);
      #1;
      check("scanEnable", {5'h00, scanEnable}, 8'h02);
      strobe();
      rdChk(8'h03, 8'h02);
      rdChk(8'h00, 8'h21);
      host.wr(8'h00, 8'h31);
      // the status wipe follows one cycle after deep sleep is registered
      @(posedge mclk);
      #1;
      check("scanEnable", {5'h00, scanEnable}, 8'h00);
      check("alertN", {7'h00, alertN}, 8'h01);
      rdChk(8'h03, 8'h00);
      rdChk(8'h02, 8'h00);
      rdChk(8'h00, 8'h30);
      host.wr(8'h00, 8'h00);
      #1;
      check("scanEnable", {5'h00, scanEnable}, 8'h07);
      $display("test power states done");
      final_report();
   end
endmodule : tb
